/* File: src/smp_pkg.sv */
// Package with constants and types shared by both ends of the serial port.
package smp_pkg;
    localparam int SMP_BITS = 8;
    localparam logic [3:0] SMP_BITS_IN_SESSION = 4'hF;
    localparam logic [7:0] SMP_ADDR_CR_A1 = 8'h00;
    localparam logic [7:0] SMP_ADDR_CR_B1 = 8'h20;
    localparam logic [7:0] SMP_RST_CR_A1 = 8'h00;
    localparam logic [7:0] SMP_RST_CR_B1 = 8'h02;
    localparam int SMP_ADDR_W = 7;
    localparam int SMP_REGS = 128;
    // Command byte layout, MSB-first mode: bit 7 read flag, bits 6:0 address.
    localparam int SMP_MSB_RW_POS = 7;
    // Command byte layout, LSB-first mode: bit 0 read flag, bits 7:1 address.
    localparam int SMP_LSB_RW_POS = 0;
    // Host clock divider: last count of the divider; a link clock half period is this plus one system cycles.
    localparam logic [3:0] SMP_HALF_PERIOD = 4'h4;
    typedef enum logic [1:0] {SMP_IDLE, SMP_CMD, SMP_DATA, SMP_DONE} smp_state_t;
endpackage

/* File: src/smp_link_if.sv */
// Interface joining the host end and the device end of the serial port.
`timescale 1ns/1ps
interface smp_link_if;
    logic sclk;
    logic cs_n;
    logic io_host_o;
    logic io_host_oe;
    logic io_dev_o;
    logic io_dev_oe;
    logic rx_line;
    logic port_io_line;
    // The io line resolves the two enables; an undriven line reads as high.
    assign port_io_line = io_dev_oe ? io_dev_o :
        (io_host_oe ? io_host_o : 1'b1);
    modport device (input sclk, input cs_n, input port_io_line,
        input rx_line, output io_dev_o, output io_dev_oe);
    modport host (output sclk, output cs_n, output io_host_o,
        output io_host_oe, output rx_line, input port_io_line);
endinterface

/* File: src/smp_device.sv */
// Device end of the serial register port with its internal register file.
`timescale 1ns/1ps
module smp_device
    import smp_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic MODE_STRAP_A,
    input wire logic MODE_STRAP_B,
    smp_link_if.device LINK,
    output logic PORT_ENABLED,
    output logic [7:0] CR_A1,
    output logic [7:0] CR_B1
);
    // ======================================================================
    // Input synchronisers.
    logic [1:0] sclk_s_r, cs_s_r, io_s_r, rx_s_r, sa_s_r, sb_s_r;
    logic sclk_d_r, cs_d_r;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            sclk_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            io_s_r <= 2'h3;
            rx_s_r <= 2'h0;
            sa_s_r <= 2'h3;
            sb_s_r <= 2'h3;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_s_r <= {sclk_s_r[0], LINK.sclk};
            cs_s_r <= {cs_s_r[0], LINK.cs_n};
            io_s_r <= {io_s_r[0], LINK.port_io_line};
            rx_s_r <= {rx_s_r[0], LINK.rx_line};
            sa_s_r <= {sa_s_r[0], MODE_STRAP_A};
            sb_s_r <= {sb_s_r[0], MODE_STRAP_B};
            sclk_d_r <= sclk_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end
    wire logic sclk_q = sclk_s_r[1];
    wire logic cs_q = cs_s_r[1];
    wire logic enabled = ~sa_s_r[1] & ~sb_s_r[1];
    wire logic sclk_rise = sclk_q & ~sclk_d_r;
    wire logic sclk_fall = ~sclk_q & sclk_d_r;
    wire logic cs_fall = ~cs_q & cs_d_r;

    // ======================================================================
    // Register file and session state.
    logic [7:0] regs_r [SMP_REGS];
    smp_state_t state_r, state_nxt;
    logic lsb_mode_r, lsb_mode_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic rd_r, rd_nxt;
    logic [SMP_ADDR_W-1:0] addr_r, addr_nxt;
    logic drive_r, drive_nxt;
    logic out_r, out_nxt;
    logic wr_en;
    logic [7:0] wr_byte;
    logic rx_bit;
    logic [7:0] cmd;

    always_comb begin
        state_nxt = state_r;
        lsb_mode_nxt = lsb_mode_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        rd_nxt = rd_r;
        addr_nxt = addr_r;
        drive_nxt = drive_r;
        out_nxt = out_r;
        wr_en = 1'b0;
        wr_byte = 8'h00;
        // In LSB-first mode the receive line is disconnected.
        rx_bit = lsb_mode_r ? io_s_r[1] : rx_s_r[1];
        cmd = lsb_mode_r ? {rx_bit, shift_r[7:1]} : {shift_r[6:0], rx_bit};
        if (cs_q || !enabled) begin
            state_nxt = SMP_IDLE;
            drive_nxt = 1'b0;
        end else begin
            unique case (state_r)
                SMP_IDLE: begin
                    if (cs_fall) begin
                        lsb_mode_nxt = sclk_q;
                        cnt_nxt = 4'h0;
                        state_nxt = SMP_CMD;
                    end
                end
                SMP_CMD: begin
                    if (sclk_rise) begin
                        shift_nxt = cmd;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == 4'h7) begin
                            // Layout per mode.
                            rd_nxt = lsb_mode_r ? cmd[SMP_LSB_RW_POS]
                                : cmd[SMP_MSB_RW_POS];
                            addr_nxt = lsb_mode_r ? cmd[7:1] : cmd[6:0];
                            tx_nxt = regs_r[addr_nxt];
                            state_nxt = SMP_DATA;
                        end
                    end
                end
                SMP_DATA: begin
                    if (sclk_fall && rd_r) begin
                        drive_nxt = 1'b1;
                        out_nxt = lsb_mode_r ? tx_r[0] : tx_r[7];
                        tx_nxt = lsb_mode_r ? {1'b0, tx_r[7:1]}
                            : {tx_r[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        // Read sessions shift bits in too, but write nothing.
                        shift_nxt = cmd;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == SMP_BITS_IN_SESSION) begin
                            wr_en = ~rd_r;
                            wr_byte = cmd;
                            state_nxt = SMP_DONE;
                        end
                    end
                end
                SMP_DONE: begin
                    // Extra clocks before select rises are ignored.
                    if (sclk_fall) begin
                        drive_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    // The first data bit of a read must leave on the falling edge that ends
    // the eighth command clock, so the shift starts with the first fall.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state_r <= SMP_IDLE;
            lsb_mode_r <= 1'b0;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            rd_r <= 1'b0;
            addr_r <= '0;
            drive_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            lsb_mode_r <= lsb_mode_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
            drive_r <= drive_nxt;
            out_r <= out_nxt;
        end
    end

    // ======================================================================
    // Register storage, readable back after a write.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < SMP_REGS; i++) begin
                regs_r[i] <= 8'h00;
            end
            regs_r[SMP_ADDR_CR_A1[SMP_ADDR_W-1:0]] <= SMP_RST_CR_A1;
            regs_r[SMP_ADDR_CR_B1[SMP_ADDR_W-1:0]] <= SMP_RST_CR_B1;
        end else if (wr_en) begin
            regs_r[addr_r] <= wr_byte;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PORT_ENABLED <= 1'b0;
            CR_A1 <= SMP_RST_CR_A1;
            CR_B1 <= SMP_RST_CR_B1;
        end else begin
            PORT_ENABLED <= enabled;
            CR_A1 <= regs_r[SMP_ADDR_CR_A1[SMP_ADDR_W-1:0]];
            CR_B1 <= regs_r[SMP_ADDR_CR_B1[SMP_ADDR_W-1:0]];
        end
    end

    assign LINK.io_dev_o = out_r;
    assign LINK.io_dev_oe = drive_r;
endmodule

/* File: src/smp_host.sv */
// Host end of the serial register port: runs one two-byte session.
`timescale 1ns/1ps
module smp_host
    import smp_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic REQ,
    input wire logic REQ_READ,
    input wire logic REQ_LSB_MODE,
    input wire logic [6:0] REQ_ADDR,
    input wire logic [7:0] REQ_WDATA,
    smp_link_if.host LINK,
    output logic BUSY,
    output logic DONE,
    output logic [7:0] RDATA
);
    // ======================================================================
    // Session sequencer; the link clock is made here by a divider.
    logic [1:0] io_s_r;
    smp_state_t state_r, state_nxt;
    logic [3:0] div_r, div_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic sclk_r, sclk_nxt, cs_r, cs_nxt, lsb_r, lsb_nxt, rd_r, rd_nxt;
    logic [15:0] tx_r, tx_nxt;
    logic [7:0] rx_r, rx_nxt, rdata_nxt;
    logic out_r, out_nxt, oe_r, oe_nxt, done_nxt;
    logic tick;
    logic [15:0] frame_lsb;
    wire logic [7:0] cmd_lsb = {REQ_ADDR, REQ_READ};

    // LSB-first frames are stored bit-reversed per byte, so one left shift
    // serves both modes.
    for (genvar g = 0; g < 8; g++) begin : g_rev
        assign frame_lsb[15 - g] = cmd_lsb[g];
        assign frame_lsb[7 - g] = REQ_WDATA[g];
    end

    always_comb begin
        state_nxt = state_r;
        div_nxt = div_r;
        bit_nxt = bit_r;
        sclk_nxt = sclk_r;
        cs_nxt = cs_r;
        lsb_nxt = lsb_r;
        rd_nxt = rd_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        rdata_nxt = RDATA;
        done_nxt = 1'b0;
        tick = (div_r == SMP_HALF_PERIOD);
        div_nxt = tick ? 4'h0 : div_r + 4'h1;
        unique case (state_r)
            SMP_IDLE: begin
                if (REQ) begin
                    lsb_nxt = REQ_LSB_MODE;
                    rd_nxt = REQ_READ;
                    sclk_nxt = REQ_LSB_MODE;
                    tx_nxt = REQ_LSB_MODE ? frame_lsb
                        : {REQ_READ, REQ_ADDR, REQ_WDATA};
                    bit_nxt = 5'h00;
                    div_nxt = 4'h0;
                    state_nxt = SMP_CMD;
                end
            end
            SMP_CMD: begin
                // Select falls while the clock holds its mode level; the
                // clock drops only one half period later, so the device
                // never sees both move at once.
                if (tick) begin
                    if (cs_r) begin
                        cs_nxt = 1'b0;
                        oe_nxt = 1'b1;
                        out_nxt = tx_r[15];
                    end else begin
                        sclk_nxt = 1'b0;
                        state_nxt = SMP_DATA;
                    end
                end
            end
            SMP_DATA: begin
                if (tick) begin
                    sclk_nxt = ~sclk_r;
                    if (sclk_r) begin
                        // Sampling just before the fall leaves the device's
                        // resynchronised output a full half period to settle.
                        rx_nxt = lsb_r ? {io_s_r[1], rx_r[7:1]}
                            : {rx_r[6:0], io_s_r[1]};
                        bit_nxt = bit_r + 5'h01;
                        if (bit_r == 5'h0F) begin
                            state_nxt = SMP_DONE;
                        end else begin
                            tx_nxt = {tx_r[14:0], 1'b0};
                            out_nxt = tx_r[14];
                            if (bit_r == 5'h07) begin
                                oe_nxt = ~(rd_r & lsb_r);
                            end
                        end
                    end
                end
            end
            SMP_DONE: begin
                if (tick) begin
                    cs_nxt = 1'b1;
                    oe_nxt = 1'b0;
                    sclk_nxt = 1'b0;
                    rdata_nxt = rd_r ? rx_r : RDATA;
                    done_nxt = 1'b1;
                    state_nxt = SMP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            io_s_r <= 2'h3;
            state_r <= SMP_IDLE;
            div_r <= 4'h0;
            bit_r <= 5'h00;
            sclk_r <= 1'b0;
            cs_r <= 1'b1;
            lsb_r <= 1'b0;
            rd_r <= 1'b0;
            tx_r <= 16'h0000;
            rx_r <= 8'h00;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            RDATA <= 8'h00;
            DONE <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            io_s_r <= {io_s_r[0], LINK.port_io_line};
            state_r <= state_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            sclk_r <= sclk_nxt;
            cs_r <= cs_nxt;
            lsb_r <= lsb_nxt;
            rd_r <= rd_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            RDATA <= rdata_nxt;
            DONE <= done_nxt;
            BUSY <= (state_nxt != SMP_IDLE);
        end
    end

    assign LINK.sclk = sclk_r;
    assign LINK.cs_n = cs_r;
    assign LINK.io_host_o = out_r;
    assign LINK.io_host_oe = oe_r & lsb_r;
    assign LINK.rx_line = out_r;
endmodule

/* File: bench/smp_link_asserts.sv */
// Concurrent checks on the link between the host end and the device end.
`timescale 1ns/1ps
module smp_link_asserts (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic io_host_o,
    input wire logic io_host_oe,
    input wire logic io_dev_o,
    input wire logic io_dev_oe,
    input wire logic rx_line,
    input wire logic port_io_line,
    input wire logic port_en
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic sclk_d_r;
    logic cs_n_d_r;
    logic lsb_r;
    logic lsb_nxt;
    logic rd_r;
    logic rd_nxt;
    logic rise;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // =========================================
    // Session tracking.
    // The count holds after select rises, so a late release is still judged.
    assign rise = !cs_n && sclk && !sclk_d_r;
    always_comb begin
        cnt_nxt = cnt_r;
        lsb_nxt = lsb_r;
        rd_nxt = rd_r;
        if (!cs_n && cs_n_d_r) begin
            cnt_nxt = 5'h00;
            lsb_nxt = sclk;
        end else if (rise) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'h00) begin
                rd_nxt = lsb_r ? port_io_line : rx_line;
            end
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cnt_r <= 5'h00;
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
            lsb_r <= 1'b0;
            rd_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sclk_d_r <= sclk;
            cs_n_d_r <= cs_n;
            lsb_r <= lsb_nxt;
            rd_r <= rd_nxt;
        end
    end
    // =========================================
    // Link checks.
    chk_frame_len: assert property (
        $rose(cs_n) |-> cnt_r == 5'h10)
        else $error("select rose without sixteen link clocks");
    chk_no_extra: assert property (
        !cs_n |-> cnt_r <= 5'h10)
        else $error("more than sixteen link clocks in one session");
    chk_io_release: assert property (
        $rose(cs_n) |-> ##[1:4] !io_dev_oe)
        else $error("io line not released after select rose");
    chk_io_off: assert property (
        cs_n [*5] |-> !io_dev_oe)
        else $error("io line driven while select high");
    chk_oe_data: assert property (
        io_dev_oe |-> rd_r && cnt_r >= 5'h08)
        else $error("device drove io line outside read data byte");
    chk_read_drive: assert property (
        rd_r && port_en && !cs_n && cnt_r == 5'h0C |-> io_dev_oe)
        else $error("device silent during read data byte");
    chk_sel_sclk: assert property (
        $fell(cs_n) |-> $stable(sclk))
        else $error("link clock moved at select fall");
    chk_out_fall: assert property (
        io_dev_oe && $past(io_dev_oe) && $changed(io_dev_o) |-> !sclk)
        else $error("device output changed while link clock high");
    chk_no_clash: assert property (
        !(io_dev_oe && io_host_oe))
        else $error("both ends drive the io line");
endmodule

/* File: bench/serial_microport_host_interface_tb.sv */
// Self-checking bench: host end and device end joined over the link.
`timescale 1ns/1ps
module serial_microport_host_interface_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic strap_a = 1'b0;
    logic strap_b = 1'b0;
    logic req = 1'b0;
    logic req_read = 1'b0;
    logic req_lsb = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_wdata = 8'h00;
    logic busy, done, port_en;
    logic [7:0] rdata, cr_a1, cr_b1;
    logic [7:0] mem [128];
    logic [31:0] r;
    logic [7:0] last_rd = 8'h00;
    int errors = 0;
    int check_count = 0;
    smp_link_if link ();
    smp_host u_smp_host (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .REQ(req),
        .REQ_READ(req_read), .REQ_LSB_MODE(req_lsb), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .LINK(link.host), .BUSY(busy), .DONE(done),
        .RDATA(rdata));
    smp_device u_smp_device (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
        .MODE_STRAP_A(strap_a), .MODE_STRAP_B(strap_b), .LINK(link.device),
        .PORT_ENABLED(port_en), .CR_A1(cr_a1), .CR_B1(cr_b1));
    smp_link_asserts u_smp_link_asserts (.SYS_CLK(sys_clk),
        .SYS_RST(sys_rst), .sclk(link.sclk), .cs_n(link.cs_n),
        .io_host_o(link.io_host_o), .io_host_oe(link.io_host_oe),
        .io_dev_o(link.io_dev_o), .io_dev_oe(link.io_dev_oe),
        .rx_line(link.rx_line), .port_io_line(link.port_io_line),
        .port_en(port_en));
    always #12.5 sys_clk = ~sys_clk;
    // =========================================
    // Tasks.
    task automatic end_of_test();
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check8(string name, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // A disabled port leaves the io line undriven, and it reads as ones.
    task automatic session(logic rd, logic lsb, logic [6:0] a,
        logic [7:0] d);
        int n;
        logic en;
        en = !strap_a && !strap_b;
        req_read = rd;
        req_lsb = lsb;
        req_addr = a;
        req_wdata = d;
        req = 1'b1;
        tick(1);
        req = 1'b0;
        check8("busy", 8'h01, {7'h00, busy});
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        check8("done", 8'h01, {7'h00, done});
        check8("busy_end", 8'h00, {7'h00, busy});
        if (rd) begin
            last_rd = en ? mem[a] : 8'hFF;
            check8("rdata", last_rd, rdata);
        end else begin
            check8("rdata_keep", last_rd, rdata);
            if (en) begin
                mem[a] = d;
            end
        end
        check8("cr_a1", mem[7'h00], cr_a1);
        check8("cr_b1", mem[7'h20], cr_b1);
    endtask
    // =========================================
    // Main sequence.
    initial begin
        void'($urandom(32'h7AC7));
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        mem[7'h20] = 8'h02;
        tick(8);
        sys_rst = 1'b0;
        tick(4);
        check8("port_en", 8'h01, {7'h00, port_en});
        for (int m = 0; m < 2; m++) begin
            session(1'b1, m[0], 7'h20, 8'h00);
            session(1'b0, m[0], 7'h7F, 8'hA5 ^ {8{m[0]}});
            session(1'b1, !m[0], 7'h7F, 8'h00);
            session(1'b0, !m[0], 7'h00, 8'h81);
            session(1'b1, m[0], 7'h00, 8'h00);
        end
        for (int s = 1; s < 4; s++) begin
            strap_a = s[0];
            strap_b = s[1];
            tick(4);
            check8("port_en", 8'h00, {7'h00, port_en});
            session(1'b0, s[0], 7'h00, 8'h5A);
            session(1'b1, s[1], 7'h20, 8'h00);
        end
        strap_a = 1'b0;
        strap_b = 1'b0;
        tick(4);
        for (int i = 0; i < 60; i++) begin
            r = $urandom;
            if (r[3:2] == 2'h0) begin
                r[10:4] = {1'b0, r[4], 5'h00};
            end
            session(r[0], r[1], r[10:4], r[18:11]);
        end
        end_of_test();
    end
    // About 75 sessions of under 200 cycles each; this leaves wide margin.
    initial begin
        #(40000 * 25);
        errors++;
        end_of_test();
    end
endmodule
